// ---- core/t1f_fifo.sv ----
// Small FIFO carrying link message bytes toward the serializer
`default_nettype none
module t1f_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock, // System clock
	input wire logic resetn, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic [WIDTH-1:0] in_data, // Write data
	input wire logic in_valid, // Write request
	output logic in_ready, // Room available
	output logic [WIDTH-1:0] out_data, // Head word
	output logic out_valid, // Head word present
	input wire logic out_ready // Pop request
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("DEPTH must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire logic push = in_valid & in_ready;
	wire logic pop = out_valid & out_ready;
	wire logic [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	assign out_valid = count != '0;
	assign out_data = mem[rd_ptr];
	// Pointers, fill level and registered ready
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b0;
		end else if (ce) begin
			wr_ptr <= wr_ptr + AW'(push);
			rd_ptr <= rd_ptr + AW'(pop);
			count <= next_count;
			in_ready <= next_count != (AW+1)'(DEPTH);
		end
	end
	// Storage array, no reset needed
	always_ff @(posedge clock) begin
		if (ce && push) begin
			mem[wr_ptr] <= in_data;
		end
	end
	AST_FIFO_BOUND: assert property (@(posedge clock) disable iff (!resetn)
		count <= (AW+1)'(DEPTH))
		else $error("FIFO fill level out of bounds");
	// A pop at full may reopen room on the next edge, so check same cycle
	AST_FIFO_FULL: assert property (@(posedge clock) disable iff (!resetn)
		(count == (AW+1)'(DEPTH)) |-> !in_ready)
		else $error("FIFO offered room while full");
endmodule // t1f_fifo
`default_nettype wire

// ---- core/t1f_lof.sv ----
// Loss-of-frame monitor counting framing bit errors per block
`default_nettype none
module t1f_lof (
	input wire logic clock, // System clock
	input wire logic resetn, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire logic clear, // Restart counting, framer not aligned
	input wire logic strobe, // A framing bit was checked
	input wire logic error, // That framing bit was wrong
	input wire logic [2:0] tolerance, // Errors that declare the defect
	input wire logic [2:0] window, // Framing bits per block
	output logic lof_event // One-cycle defect pulse
);
	logic [2:0] bit_cnt;
	logic [2:0] err_cnt;
	// Zero settings are blocked and never declare the defect
	wire logic blocked = (tolerance == 3'h0) | (window == 3'h0);
	wire logic [2:0] errs = err_cnt + {2'b00, error};
	wire logic hit = strobe & ~clear & ~blocked & (errs >= tolerance);
	wire logic last = bit_cnt == window - 3'h1;
	// Block counters restart at each block boundary
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bit_cnt <= 3'h0;
			err_cnt <= 3'h0;
			lof_event <= 1'b0;
		end else if (ce) begin
			lof_event <= hit;
			if (clear || hit || (strobe && last)) begin
				bit_cnt <= 3'h0;
				err_cnt <= 3'h0;
			end else if (strobe) begin
				bit_cnt <= bit_cnt + 3'h1;
				err_cnt <= errs;
			end
		end
	end
	AST_LOF_COUNT: assert property (@(posedge clock) disable iff (!resetn)
		(ce && strobe && error && !clear && !blocked &&
		err_cnt + 3'h1 == tolerance) |=> lof_event)
		else $error("Loss of frame not declared at tolerance");
	AST_TOL_ZERO: assert property (@(posedge clock) disable iff (!resetn)
		(ce && tolerance == 3'h0) |=> !lof_event)
		else $error("Zero tolerance declared loss of frame");
	AST_RANGE_ZERO: assert property (@(posedge clock) disable iff (!resetn)
		(ce && window == 3'h0) |=> !lof_event)
		else $error("Zero range declared loss of frame");
	AST_BLOCK_RESTART: assert property (@(posedge clock) disable iff (!resetn)
		(ce && strobe && last) |=> (bit_cnt == 3'h0 && err_cnt == 3'h0))
		else $error("Error count not restarted at block end");
endmodule // t1f_lof
`default_nettype wire

// ---- core/t1f_pkg.sv ----
// Shared constants and types for the T1 data link and frame sync block
`default_nettype none
package t1f_pkg;
	// Register indexes; byte address is four times the index
	localparam int ADDR_W = 12;
	localparam logic [11:0] TX_SEL_IDX = 12'h10A;
	localparam logic [11:0] RX_SYNC_IDX = 12'h10B;
	localparam logic [11:0] STATUS_IDX = 12'h110;
	// Field positions
	localparam int SRC_LSB = 0;
	localparam int BW_LSB = 4;
	localparam int REFRAME_BIT = 7;
	localparam int CRC_BIT = 6;
	localparam int TOL_LSB = 3;
	localparam int RANGE_LSB = 0;
	localparam int ST_LSB = 2;
	// Reset values
	localparam logic [7:0] TX_SEL_RST = 8'h00;
	localparam logic [7:0] RX_SYNC_RST = 8'h43;
	// Data path sizes and counts
	localparam int FIFO_DEPTH = 8;
	localparam int MSG_W = 8;
	localparam logic [2:0] BYTE_LAST = 3'h7;
	localparam logic IDLE_BIT = 1'b1;
	typedef enum logic [1:0] {
		SRC_MSG = 2'h0,
		SRC_SER = 2'h1,
		SRC_OH = 2'h2,
		SRC_ONES = 2'h3
	} t1f_dl_src_t;
	typedef enum logic [1:0] {
		BW_EVERY = 2'h0,
		BW_ODD = 2'h1,
		BW_EVEN = 2'h2,
		BW_RSVD = 2'h3
	} t1f_bw_t;
	typedef enum logic [1:0] {
		MSG_CTL1 = 2'h0,
		MSG_CTL2 = 2'h1,
		MSG_CTL3 = 2'h2,
		MSG_SLB = 2'h3
	} t1f_msg_id_t;
	typedef enum logic [1:0] {ST_SEARCH, ST_CRC, ST_IN} t1f_sync_t;
	typedef struct packed {
		t1f_msg_id_t id;
		logic [MSG_W-1:0] data;
	} t1f_msg_t;
	typedef struct packed {
		logic dl_slot;
		logic frame_odd;
	} t1f_tx_slot_t;
	typedef struct packed {
		logic fbit_strobe;
		logic fbit_error;
		logic pattern_found;
		logic crc_strobe;
		logic crc_ok;
	} t1f_rx_stat_t;
	function automatic logic [11:0] byte_addr(input logic [11:0] idx);
		return {idx[9:0], 2'b00};
	endfunction
endpackage
`default_nettype wire

// ---- core/t1f_top.sv ----
// T1 transmit data link source select and receive frame sync control
//
// Contract
// - Source 00 sends bits from message controller one or loop buffer.
// - Only message controller one or the loop buffer may feed data link bit positions.
// - Source 01 sends data link bits from the serial data pin.
// - Source 10 sends data link bits from the overhead pin.
// - Source 11 forces every data link bit to one.
// - A 0-to-1 force-reframe write restarts the synchronization search.
// - Force-reframe clears itself once frame alignment is reached again.
// - CRC-check set means ESF needs good CRC before in-frame.
// - Tolerance-many framing errors within range bits declare loss of frame.
// - Zero tolerance is blocked internally; software programs a nonzero one.
// - Zero range is blocked internally; software programs a nonzero one.
// - Reset: range 011, tolerance 000, CRC-check 1, source 00.
// - Bandwidth select only applies in ESF; other formats use every slot.
`default_nettype none
module t1f_top #(
	parameter int DEPTH = t1f_pkg::FIFO_DEPTH
) (
	input wire logic clock, // 125 MHz system clock
	input wire logic resetn, // Async reset, active low
	input wire logic ce, // Clock enable, freezes all state
	input wire logic [11:0] avs_address, // Avalon byte address
	input wire logic avs_read, // Avalon read
	input wire logic avs_write, // Avalon write
	input wire logic [31:0] avs_writedata, // Avalon write data
	input wire logic [3:0] avs_byteenable, // Avalon byte enables
	output logic [31:0] avs_readdata, // Avalon read data
	output logic avs_waitrequest, // Avalon wait
	input wire t1f_pkg::t1f_msg_t msg_in, // Message byte and origin
	input wire logic msg_valid, // Message byte offered
	output logic msg_ready, // Message byte taken
	input wire t1f_pkg::t1f_tx_slot_t tx_slot, // Outbound slot marks
	input wire logic esf_mode, // Framing format is ESF
	input wire logic tx_serial_data_in, // Serial data pin
	input wire logic tx_overhead_in, // Overhead pin
	output logic tx_dl_bit, // Data link bit to insert
	output logic tx_dl_insert, // Insert tx_dl_bit now
	input wire t1f_pkg::t1f_rx_stat_t rx_stat, // Receive framer events
	output logic rx_restart, // Restart search pulse
	output logic in_frame, // Framer aligned
	output logic lof // Loss-of-frame defect
);
	// Registers and state
	logic [7:0] tx_sel;
	logic [7:0] rx_sync;
	logic reframe_q;
	logic ser_m;
	logic ser_s;
	logic oh_m;
	logic oh_s;
	logic [7:0] shreg;
	logic [2:0] bits_left;
	t1f_pkg::t1f_sync_t state;
	t1f_pkg::t1f_sync_t next_state;
	logic next_dl_bit;
	logic [31:0] rd_data;
	logic lof_event;
	logic fifo_valid;
	logic [7:0] fifo_data;

	// Bus access decode
	wire logic req = avs_read | avs_write;
	wire logic take = req & ~avs_waitrequest;
	wire logic lane0 = avs_byteenable[0];
	wire logic hit_tx = avs_address == t1f_pkg::byte_addr(t1f_pkg::TX_SEL_IDX);
	wire logic hit_rx = avs_address == t1f_pkg::byte_addr(t1f_pkg::RX_SYNC_IDX);
	wire logic hit_st = avs_address == t1f_pkg::byte_addr(t1f_pkg::STATUS_IDX);
	wire logic wr_tx = take & avs_write & lane0 & hit_tx;
	wire logic wr_rx = take & avs_write & lane0 & hit_rx;

	// Register fields
	wire t1f_pkg::t1f_dl_src_t tx_src =
		t1f_pkg::t1f_dl_src_t'(tx_sel[t1f_pkg::SRC_LSB +: 2]);
	wire t1f_pkg::t1f_bw_t tx_bw =
		t1f_pkg::t1f_bw_t'(tx_sel[t1f_pkg::BW_LSB +: 2]);
	wire logic reframe = rx_sync[t1f_pkg::REFRAME_BIT];
	wire logic crc_en = rx_sync[t1f_pkg::CRC_BIT];
	wire logic [2:0] tol = rx_sync[t1f_pkg::TOL_LSB +: 3];
	wire logic [2:0] rng = rx_sync[t1f_pkg::RANGE_LSB +: 3];

	// Read data selection, unmapped addresses read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		if (hit_tx) begin
			rd_data[7:0] = tx_sel;
		end else if (hit_rx) begin
			rd_data[7:0] = rx_sync;
		end else if (hit_st) begin
			rd_data[0] = in_frame;
			rd_data[1] = lof;
			rd_data[t1f_pkg::ST_LSB +: 2] = 2'(state);
		end
	end

	// Avalon slave: one wait cycle, then the access completes
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if (ce) begin
			avs_waitrequest <= ~(req & avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= rd_data;
			end
		end
	end

	// Pin synchronisers for the serial and overhead inputs
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ser_m <= 1'b0;
			ser_s <= 1'b0;
			oh_m <= 1'b0;
			oh_s <= 1'b0;
		end else if (ce) begin
			ser_m <= tx_serial_data_in;
			ser_s <= ser_m;
			oh_m <= tx_overhead_in;
			oh_s <= oh_m;
		end
	end

	// Data link slot use; bandwidth select counts in ESF only
	wire logic bw_ok = (tx_bw == t1f_pkg::BW_EVERY) |
		(tx_bw == t1f_pkg::BW_RSVD) |
		((tx_bw == t1f_pkg::BW_ODD) & tx_slot.frame_odd) |
		((tx_bw == t1f_pkg::BW_EVEN) & ~tx_slot.frame_odd);
	wire logic slot_use = tx_slot.dl_slot & (~esf_mode | bw_ok);

	// Only controller one or the loop buffer may enter the link path
	wire logic msg_link = (msg_in.id == t1f_pkg::MSG_CTL1) |
		(msg_in.id == t1f_pkg::MSG_SLB);
	wire logic fifo_in_valid = msg_valid & msg_link;
	wire logic use_msg = slot_use & (tx_src == t1f_pkg::SRC_MSG);
	wire logic load = use_msg & (bits_left == 3'h0) & fifo_valid;

	t1f_fifo #(
		.WIDTH(t1f_pkg::MSG_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.ce(ce),
		.in_data(msg_in.data),
		.in_valid(fifo_in_valid),
		.in_ready(msg_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(load)
	);

	// Bit chosen for the current data link slot
	always_comb begin
		next_dl_bit = t1f_pkg::IDLE_BIT;
		unique case (tx_src)
			t1f_pkg::SRC_MSG: begin
				if (load) begin
					next_dl_bit = fifo_data[7];
				end else if (bits_left != 3'h0) begin
					next_dl_bit = shreg[7];
				end
			end
			t1f_pkg::SRC_SER: next_dl_bit = ser_s;
			t1f_pkg::SRC_OH: next_dl_bit = oh_s;
			t1f_pkg::SRC_ONES: next_dl_bit = 1'b1;
		endcase
	end

	// Outbound bit register and message byte serializer, MSB first
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tx_dl_bit <= t1f_pkg::IDLE_BIT;
			tx_dl_insert <= 1'b0;
			shreg <= 8'h00;
			bits_left <= 3'h0;
		end else if (ce) begin
			tx_dl_insert <= slot_use;
			if (slot_use) begin
				tx_dl_bit <= next_dl_bit;
			end
			if (load) begin
				shreg <= {fifo_data[6:0], 1'b0};
				bits_left <= t1f_pkg::BYTE_LAST;
			end else if (use_msg && bits_left != 3'h0) begin
				shreg <= {shreg[6:0], 1'b0};
				bits_left <= bits_left - 3'h1;
			end
		end
	end

	// Framer synchronisation control
	wire logic reframe_rise = reframe & ~reframe_q;
	wire logic crc_gate = esf_mode & crc_en;
	wire logic reach_in = (state != t1f_pkg::ST_IN) &
		(next_state == t1f_pkg::ST_IN);

	always_comb begin
		next_state = state;
		if (reframe_rise || lof_event) begin
			next_state = t1f_pkg::ST_SEARCH;
		end else begin
			unique case (state)
				t1f_pkg::ST_SEARCH: begin
					if (rx_stat.pattern_found) begin
						next_state = crc_gate ? t1f_pkg::ST_CRC :
							t1f_pkg::ST_IN;
					end
				end
				t1f_pkg::ST_CRC: begin
					if (rx_stat.crc_strobe) begin
						next_state = rx_stat.crc_ok ? t1f_pkg::ST_IN :
							t1f_pkg::ST_SEARCH;
					end
				end
				t1f_pkg::ST_IN: next_state = t1f_pkg::ST_IN;
				default: next_state = t1f_pkg::ST_SEARCH;
			endcase
		end
	end

	// Control registers; a software write wins over the self-clear
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tx_sel <= t1f_pkg::TX_SEL_RST;
			rx_sync <= t1f_pkg::RX_SYNC_RST;
		end else if (ce) begin
			if (wr_tx) begin
				tx_sel <= avs_writedata[7:0];
			end
			if (wr_rx) begin
				rx_sync <= avs_writedata[7:0];
			end else if (reach_in) begin
				rx_sync[t1f_pkg::REFRAME_BIT] <= 1'b0;
			end
		end
	end

	// Sync state, restart pulse and status flags
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= t1f_pkg::ST_SEARCH;
			reframe_q <= 1'b0;
			rx_restart <= 1'b0;
			in_frame <= 1'b0;
			lof <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			reframe_q <= reframe;
			rx_restart <= reframe_rise | lof_event;
			in_frame <= next_state == t1f_pkg::ST_IN;
			if (lof_event) begin
				lof <= 1'b1;
			end else if (reach_in) begin
				lof <= 1'b0;
			end
		end
	end

	// Error monitor runs only while aligned
	t1f_lof u_lof (
		.clock(clock),
		.resetn(resetn),
		.ce(ce),
		.clear(state != t1f_pkg::ST_IN),
		.strobe(rx_stat.fbit_strobe),
		.error(rx_stat.fbit_error),
		.tolerance(tol),
		.window(rng),
		.lof_event(lof_event)
	);

	// Checks on the transmit path
	AST_SRC_SER: assert property (@(posedge clock) disable iff (!resetn)
		(ce && slot_use && tx_src == t1f_pkg::SRC_SER) |=>
		(tx_dl_insert && tx_dl_bit == $past(ser_s)))
		else $error("Serial pin bit not inserted");
	AST_SRC_OH: assert property (@(posedge clock) disable iff (!resetn)
		(ce && slot_use && tx_src == t1f_pkg::SRC_OH) |=>
		(tx_dl_insert && tx_dl_bit == $past(oh_s)))
		else $error("Overhead pin bit not inserted");
	AST_SRC_ONES: assert property (@(posedge clock) disable iff (!resetn)
		(ce && slot_use && tx_src == t1f_pkg::SRC_ONES) |=>
		(tx_dl_insert && tx_dl_bit))
		else $error("Forced-one data link bit was zero");
	AST_SRC_MSG: assert property (@(posedge clock) disable iff (!resetn)
		(ce && load) |=> (tx_dl_bit == $past(fifo_data[7]) &&
		bits_left == t1f_pkg::BYTE_LAST))
		else $error("Message byte not started MSB first");
	AST_CTL_ONLY1: assert property (@(posedge clock) disable iff (!resetn)
		(msg_valid && (msg_in.id == t1f_pkg::MSG_CTL2 ||
		msg_in.id == t1f_pkg::MSG_CTL3)) |-> !fifo_in_valid)
		else $error("Other controller reached the data link");
	AST_BW_NON_ESF: assert property (@(posedge clock) disable iff (!resetn)
		(ce && !esf_mode && tx_slot.dl_slot) |=> tx_dl_insert)
		else $error("Non-ESF slot skipped by bandwidth select");

	// Checks on synchronisation control, register reset values and bus wait timing
	sequence seq_reframe_req;
		ce && reframe_rise;
	endsequence
	sequence seq_restart_seen;
		rx_restart && state == t1f_pkg::ST_SEARCH && !in_frame;
	endsequence
	AST_REFRAME: assert property (@(posedge clock) disable iff (!resetn)
		seq_reframe_req |=> seq_restart_seen)
		else $error("Force reframe did not restart the search");
	AST_AUTOCLR: assert property (@(posedge clock) disable iff (!resetn)
		(ce && reach_in && !wr_rx) |=> (!reframe && in_frame))
		else $error("Force reframe not cleared at alignment");
	sequence seq_found_crc;
		ce && state == t1f_pkg::ST_SEARCH && !reframe_rise &&
		!lof_event && rx_stat.pattern_found && crc_gate;
	endsequence
	AST_CRC_GATE: assert property (@(posedge clock) disable iff (!resetn)
		seq_found_crc |=> (state == t1f_pkg::ST_CRC && !in_frame))
		else $error("In-frame declared without CRC check");
	AST_LOF_DECL: assert property (@(posedge clock) disable iff (!resetn)
		(ce && lof_event) |=> (lof && state == t1f_pkg::ST_SEARCH &&
		rx_restart))
		else $error("Loss of frame not declared");
	AST_LOF_HOLD: assert property (@(posedge clock) disable iff (!resetn)
		(ce && lof && next_state != t1f_pkg::ST_IN) |=> lof)
		else $error("Loss of frame dropped while unaligned");
	AST_RESET_VAL: assert property (@(posedge clock)
		$rose(resetn) |-> (rng == 3'h3 && tol == 3'h0 && crc_en &&
		tx_src == t1f_pkg::SRC_MSG))
		else $error("Register reset values wrong");
	AST_BUS_ONE_WAIT: assert property (@(posedge clock) disable iff (!resetn)
		(ce && req && avs_waitrequest) |=> !avs_waitrequest)
		else $error("Bus access not answered after one wait cycle");
endmodule // t1f_top
`default_nettype wire

// ---- dv/t1f_line_model.sv ----
// Stand-in for the line side and terminal equipment around the block
`default_nettype none
module t1f_line_model (
	input wire logic clock, // System clock
	output var t1f_pkg::t1f_tx_slot_t tx_slot, // Outbound slot marks
	output var logic tx_serial_data_in, // Serial data pin
	output var logic tx_overhead_in, // Overhead pin
	output var t1f_pkg::t1f_rx_stat_t rx_stat // Receive framer events
);
	timeunit 1ns;
	timeprecision 1ps;
	// Quiet line at time zero
	initial begin
		tx_slot = '0;
		rx_stat = '0;
		tx_serial_data_in = 1'b0;
		tx_overhead_in = 1'b1;
	end
	// Terminal equipment holds its pins at a chosen level
	task automatic set_pins(input logic ser, input logic oh);
		@(posedge clock);
		tx_serial_data_in <= ser;
		tx_overhead_in <= oh;
	endtask
	// One data link bit position, odd or even frame
	task automatic slot_pulse(input logic odd);
		@(posedge clock);
		tx_slot <= '{dl_slot: 1'b1, frame_odd: odd};
		@(posedge clock);
		tx_slot <= '0;
	endtask
	// One cycle of framer events, order strobe error found crc ok
	task automatic event_pulse(input logic [4:0] s);
		@(posedge clock);
		rx_stat <= s;
		@(posedge clock);
		rx_stat <= '0;
	endtask
endmodule // t1f_line_model
`default_nettype wire

// ---- dv/t1f_top_tb.sv ----
// Self-checking bench for the data link select and frame sync block
`default_nettype none
module t1f_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] A_TX = 12'h428;
	localparam logic [11:0] A_RX = 12'h42C;
	localparam logic [11:0] A_ST = 12'h440;
	localparam logic [4:0] EV_PAT = 5'h04;
	localparam logic [4:0] EV_OK = 5'h10;
	localparam logic [4:0] EV_ERR = 5'h18;
	localparam logic [4:0] EV_GOOD = 5'h03;
	localparam logic [4:0] EV_BAD = 5'h02;
	logic clock, resetn, avs_read, avs_write, avs_waitrequest, msg_valid;
	logic msg_ready, esf_mode, tx_dl_bit, tx_dl_insert, rx_restart;
	logic in_frame, lof, ser, oh, seen, ce;
	logic [11:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable;
	logic [7:0] bytes [8];
	t1f_pkg::t1f_msg_t msg_in;
	t1f_pkg::t1f_tx_slot_t tx_slot;
	t1f_pkg::t1f_rx_stat_t rx_stat;
	int fails, n_compared, k, b;
	t1f_top uut (.clock(clock), .resetn(resetn), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .msg_in(msg_in),
		.msg_valid(msg_valid), .msg_ready(msg_ready), .tx_slot(tx_slot),
		.esf_mode(esf_mode), .tx_serial_data_in(ser),
		.tx_overhead_in(oh), .tx_dl_bit(tx_dl_bit),
		.tx_dl_insert(tx_dl_insert), .rx_stat(rx_stat),
		.rx_restart(rx_restart), .in_frame(in_frame), .lof(lof));
	t1f_line_model line (.clock(clock), .tx_slot(tx_slot),
		.tx_serial_data_in(ser), .tx_overhead_in(oh), .rx_stat(rx_stat));
	// Free-running 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Verdict and end of run
	task automatic complete_run;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Compare one observed value with its expectation
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [7:0] d);
		int i;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= wr;
		avs_read <= ~wr;
		for (i = 0; i < 16; i++) begin
			@(posedge clock);
			if (avs_waitrequest === 1'b0)
				break;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (i == 16) begin
			fails++;
			complete_run();
		end
	endtask
	// Offer one message byte until the FIFO takes it
	task automatic push(input t1f_pkg::t1f_msg_t m);
		int i;
		@(posedge clock);
		msg_in <= m;
		msg_valid <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clock);
			if (msg_ready === 1'b1)
				break;
		end
		msg_valid <= 1'b0;
		if (i == 16) begin
			fails++;
			complete_run();
		end
	endtask
	// Slot, then look at the insert pulse one cycle later
	task automatic slot_check(input logic odd, input logic ins,
		input logic bit_exp);
		line.slot_pulse(odd);
		@(negedge clock);
		check({31'h0, tx_dl_insert}, {31'h0, ins});
		if (ins)
			check({31'h0, tx_dl_bit}, {31'h0, bit_exp});
	endtask
	// Framing bit checks, error where the pattern has a one
	task automatic fbits(input logic [9:0] pat, input int n);
		for (int i = n - 1; i >= 0; i--)
			line.event_pulse(pat[i] ? EV_ERR : EV_OK);
		repeat (3) @(negedge clock);
	endtask
	// Expected data link bit for a source code
	function automatic logic exp_bit(input logic [1:0] src, input logic s,
		input logic o, input logic mb);
		case (src)
			2'h0: return mb;
			2'h1: return s;
			2'h2: return o;
			default: return 1'b1;
		endcase
	endfunction
	// Hang guard
	initial begin
		repeat (100000) @(posedge clock);
		fails++;
		complete_run();
	end
	// Main sequence
	initial begin
		resetn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = '0;
		avs_writedata = '0;
		avs_byteenable = 4'hF;
		msg_in = '0;
		msg_valid = 1'b0;
		esf_mode = 1'b0;
		ce = 1'b1;
		fails = 0;
		n_compared = 0;
		void'($urandom(32'hD911A1B0));
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		bus(1'b0, A_TX, 8'h00);
		check(q, 32'h00);
		bus(1'b0, A_RX, 8'h00);
		check(q, 32'h43);
		bus(1'b0, 12'h004, 8'h00);
		check(q, 32'h00);
		bus(1'b1, A_TX, 8'h33);
		bus(1'b0, A_TX, 8'h00);
		check(q, 32'h33);
		$display("test registers done");
		// Pin, forced and idle message sources with random pin levels
		for (k = 1; k < 13; k++) begin
			line.set_pins(1'($urandom), 1'($urandom));
			bus(1'b1, A_TX, 8'(k % 4));
			repeat (4) @(posedge clock);
			slot_check(1'b0, 1'b1,
				exp_bit(2'(k % 4), ser, oh, t1f_pkg::IDLE_BIT));
		end
		// Bandwidth select only in ESF, odd then even frames
		@(posedge clock);
		esf_mode <= 1'b1;
		bus(1'b1, A_TX, 8'h13);
		slot_check(1'b0, 1'b0, 1'b1);
		slot_check(1'b1, 1'b1, 1'b1);
		bus(1'b1, A_TX, 8'h23);
		slot_check(1'b1, 1'b0, 1'b1);
		slot_check(1'b0, 1'b1, 1'b1);
		@(posedge clock);
		esf_mode <= 1'b0;
		slot_check(1'b1, 1'b1, 1'b1);
		slot_check(1'b0, 1'b1, 1'b1);
		$display("test sources done");
		// Fill FIFO, other controllers discarded, then drain MSB first
		bus(1'b1, A_TX, 8'h00);
		push('{id: t1f_pkg::MSG_CTL2, data: 8'(~$urandom)});
		for (k = 0; k < 8; k++) begin
			bytes[k] = 8'($urandom);
			if (k == 4)
				push('{id: t1f_pkg::MSG_CTL3, data: ~bytes[3]});
			push('{id: k[0] ? t1f_pkg::MSG_SLB : t1f_pkg::MSG_CTL1,
				data: bytes[k]});
		end
		@(negedge clock);
		check({31'h0, msg_ready}, 32'h0);
		for (k = 0; k < 8; k++)
			for (b = 7; b >= 0; b--)
				slot_check(1'b0, 1'b1, bytes[k][b]);
		slot_check(1'b1, 1'b1, 1'b1);
		check({31'h0, msg_ready}, 32'h1);
		$display("test message path done");
		// ESF alignment waits for a good CRC
		@(posedge clock);
		esf_mode <= 1'b1;
		line.event_pulse(EV_PAT);
		line.event_pulse(EV_BAD);
		@(negedge clock);
		check({31'h0, in_frame}, 32'h0);
		line.event_pulse(EV_PAT);
		line.event_pulse(EV_GOOD);
		@(negedge clock);
		check({31'h0, in_frame}, 32'h1);
		// Forced reframe and its self-clear
		bus(1'b1, A_RX, 8'hC3);
		seen = 1'b0;
		repeat (4) begin
			@(negedge clock);
			seen = seen | rx_restart;
		end
		check({31'h0, seen}, 32'h1);
		check({31'h0, in_frame}, 32'h0);
		line.event_pulse(EV_PAT);
		line.event_pulse(EV_GOOD);
		bus(1'b0, A_RX, 8'h00);
		check(q, 32'h43);
		$display("test alignment done");
		// Loss of frame, tolerance 2 in blocks of 5, CRC off
		bus(1'b1, A_RX, 8'h15);
		bus(1'b0, A_ST, 8'h00);
		check(q, 32'h09);
		fbits(10'h030, 10);
		check({31'h0, lof}, 32'h0);
		fbits(10'h009, 4);
		check({31'h0, lof}, 32'h1);
		check({31'h0, in_frame}, 32'h0);
		repeat (20) @(posedge clock);
		bus(1'b0, A_ST, 8'h00);
		check(q, 32'h02);
		line.event_pulse(EV_PAT);
		@(negedge clock);
		check({30'h0, lof, in_frame}, 32'h1);
		// Clock enable low freezes the monitor against framing errors
		@(posedge clock);
		ce <= 1'b0;
		fbits(10'h3FF, 10);
		@(posedge clock);
		ce <= 1'b1;
		@(negedge clock);
		check({30'h0, lof, in_frame}, 32'h1);
		// Zero tolerance and zero range never declare loss of frame
		bus(1'b1, A_RX, 8'h05);
		fbits(10'h3FF, 10);
		check({31'h0, lof}, 32'h0);
		bus(1'b1, A_RX, 8'h10);
		fbits(10'h3FF, 10);
		check({30'h0, lof, in_frame}, 32'h1);
		$display("test loss of frame done");
		complete_run();
	end
endmodule // t1f_top_tb
`default_nettype wire
